// ### hw/sub_skip_alu.sv
// Combinational arithmetic: borrow subtract and decrement with flags.
// Assumes operands are stable for the whole cycle they are used in.
`timescale 1ns/10ps
`include "sub_skip_params.svh"
module sub_skip_alu #(
   parameter int WIDTH = `DATA_W
) (
   input wire logic [WIDTH-1:0] i_wreg,
   input wire logic [WIDTH-1:0] i_mem,
   input wire logic i_carry,
   input wire logic i_decrement,
   output logic [WIDTH-1:0] o_result,
   output logic o_ov,
   output logic o_ac,
   output logic o_c,
   output logic o_zero
);
   logic [WIDTH:0] sum;
   logic [`NIBBLE_W:0] low;
   logic [WIDTH-1:0] sub_b;
   initial begin
      if (WIDTH <= `NIBBLE_W) begin
         $error("WIDTH too small");
      end
   end
   always_comb begin
      sub_b = ~i_mem;
      sum = {1'b0, i_wreg} + {1'b0, sub_b} + {{WIDTH{1'b0}}, i_carry};
      low = {1'b0, i_wreg[`NIBBLE_W-1:0]} + {1'b0, sub_b[`NIBBLE_W-1:0]}
         + {{`NIBBLE_W{1'b0}}, i_carry};
      if (i_decrement) begin
         o_result = i_mem - WIDTH'(`DEC_ONE);
      end else begin
         o_result = sum[WIDTH-1:0];
      end
      o_c = sum[WIDTH];
      o_ac = low[`NIBBLE_W];
      o_ov = (i_wreg[WIDTH-1] != i_mem[WIDTH-1])
         && (sum[WIDTH-1] != i_wreg[WIDTH-1]);
      o_zero = (o_result == '0);
   end
endmodule

// ### hw/sub_skip_exec.sv
// Execution unit for borrow-subtract and decrement-skip-on-zero opcodes.
// Assumes the sequencer presents one decoded opcode per cycle with the
// memory operand already read, and honours o_stall by holding fetch.
// Operation
// - Borrow subtract result goes to working register.
// - Borrow subtract result goes back to memory.
// - Decrement memory byte, write back, test zero.
// - Zero result discards prefetch, adds dummy cycle.
// - Nonzero result continues without dummy cycle.
// - Register variant writes register, memory untouched.
// - Register variant uses same zero skip.
`timescale 1ns/10ps
`include "sub_skip_params.svh"
module sub_skip_exec #(
   parameter int WIDTH = `DATA_W
) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_valid,
   input wire logic [2:0] i_op,
   input wire logic [WIDTH-1:0] i_mem_data,
   output logic [WIDTH-1:0] o_wreg,
   output logic o_flag_ov,
   output logic o_flag_z,
   output logic o_flag_ac,
   output logic o_flag_c,
   output logic o_mem_we,
   output logic [WIDTH-1:0] o_mem_wdata,
   output logic o_discard,
   output logic o_stall,
   output logic o_done
);
   sub_skip_pkg::seq_state_e state;
   sub_skip_pkg::op_e op;
   logic [WIDTH-1:0] result;
   logic alu_ov;
   logic alu_ac;
   logic alu_c;
   logic alu_zero;
   logic is_sub;
   logic is_dec;
   logic take;
   logic sel_sub_wreg;
   logic sel_sub_mem;
   logic sel_dec_mem;
   logic sel_dec_wreg;
   logic writes_mem;
   logic skip_now;
   logic finish_now;
   localparam logic [`FLAG_W-1:0] FLAGS_INIT = `FLAGS_RESET;
   initial begin
      if (WIDTH != `DATA_W) begin
         $error("Only the documented data width is supported");
      end
      if ($bits(i_op) != $bits(sub_skip_pkg::op_e)) begin
         $error("Opcode port and opcode type differ in width");
      end
      if (`FLAG_OV >= `FLAG_W || `FLAG_Z >= `FLAG_W
         || `FLAG_AC >= `FLAG_W || `FLAG_C >= `FLAG_W) begin
         $error("Flag positions fall outside the flag vector");
      end
      if ($countones(sub_skip_pkg::ST_RUN) != 1
         || $countones(sub_skip_pkg::ST_DUMMY) != 1) begin
         $error("Sequencer state codes must be one-hot");
      end
   end
   always_comb begin
      op = sub_skip_pkg::op_e'(i_op);
      take = i_valid && (state == sub_skip_pkg::ST_RUN);
   end
   // Opcode decode; opcode none and unknown codes select nothing.
   always_comb begin
      sel_sub_wreg = 1'b0;
      sel_sub_mem = 1'b0;
      sel_dec_mem = 1'b0;
      sel_dec_wreg = 1'b0;
      case (op)
         sub_skip_pkg::OP_SUB_WREG: begin
            sel_sub_wreg = take;
         end
         sub_skip_pkg::OP_SUB_MEM: begin
            sel_sub_mem = take;
         end
         sub_skip_pkg::OP_DEC_MEM: begin
            sel_dec_mem = take;
         end
         sub_skip_pkg::OP_DEC_WREG: begin
            sel_dec_wreg = take;
         end
         default: begin
            sel_sub_wreg = 1'b0;
         end
      endcase
   end
   always_comb begin
      is_sub = sel_sub_wreg || sel_sub_mem;
      is_dec = sel_dec_mem || sel_dec_wreg;
      writes_mem = sel_sub_mem || sel_dec_mem;
   end
   // A zero decrement skips; a subtract or nonzero decrement finishes at once.
   always_comb begin
      skip_now = is_dec && alu_zero;
      finish_now = is_sub || (is_dec && !alu_zero);
   end
   sub_skip_alu #(
      .WIDTH(WIDTH)
   ) u_alu (
      .i_wreg(o_wreg),
      .i_mem(i_mem_data),
      .i_carry(o_flag_c),
      .i_decrement(is_dec),
      .o_result(result),
      .o_ov(alu_ov),
      .o_ac(alu_ac),
      .o_c(alu_c),
      .o_zero(alu_zero)
   );
   // Working register update.
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_wreg <= `WREG_RESET;
      end else if (take && op == sub_skip_pkg::OP_SUB_WREG) begin
         o_wreg <= result;
      end else if (take && op == sub_skip_pkg::OP_DEC_WREG) begin
         o_wreg <= result;
      end
   end
   // Memory write strobe; the register variants never write.
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_mem_we <= 1'b0;
      end else begin
         o_mem_we <= writes_mem;
      end
   end
   // Write data loads only with a write, so it stays quiet otherwise.
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_mem_wdata <= '0;
      end else if (writes_mem) begin
         o_mem_wdata <= result;
      end
   end
   // Overflow flag follows signed overflow of a borrow subtract.
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_flag_ov <= FLAGS_INIT[`FLAG_OV];
      end else if (is_sub) begin
         o_flag_ov <= alu_ov;
      end
   end
   // Zero flag follows the subtract result only.
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_flag_z <= FLAGS_INIT[`FLAG_Z];
      end else if (is_sub) begin
         o_flag_z <= alu_zero;
      end
   end
   // Auxiliary carry is the carry out of the low nibble.
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_flag_ac <= FLAGS_INIT[`FLAG_AC];
      end else if (is_sub) begin
         o_flag_ac <= alu_ac;
      end
   end
   // Carry is set when the subtract needs no borrow.
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_flag_c <= FLAGS_INIT[`FLAG_C];
      end else if (is_sub) begin
         o_flag_c <= alu_c;
      end
   end
   // Sequencer state: a zero decrement enters one dummy cycle.
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= sub_skip_pkg::ST_RUN;
      end else begin
         case (state)
            sub_skip_pkg::ST_RUN: begin
               if (skip_now) begin
                  state <= sub_skip_pkg::ST_DUMMY;
               end else begin
                  state <= sub_skip_pkg::ST_RUN;
               end
            end
            sub_skip_pkg::ST_DUMMY: begin
               state <= sub_skip_pkg::ST_RUN;
            end
            default: begin
               state <= sub_skip_pkg::ST_RUN;
            end
         endcase
      end
   end
   // Discard pulse drops the prefetched instruction after a skip.
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_discard <= 1'b0;
      end else begin
         o_discard <= skip_now;
      end
   end
   // Stall pulse holds fetch for the dummy cycle.
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_stall <= 1'b0;
      end else begin
         o_stall <= skip_now;
      end
   end
   // Completion pulse marks the end of each instruction, dummy included.
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_done <= 1'b0;
      end else begin
         o_done <= finish_now
            || (state == sub_skip_pkg::ST_DUMMY);
      end
   end
endmodule

// ### hw/sub_skip_params.svh
// Constants for the borrow-subtract and decrement-skip execution block.
// Assumes inclusion by the package and the design modules only.
`ifndef SUB_SKIP_PARAMS_SVH
`define SUB_SKIP_PARAMS_SVH
`define DATA_W 8
`define FLAG_OV 0
`define FLAG_Z 1
`define FLAG_AC 2
`define FLAG_C 3
`define FLAG_W 4
`define WREG_RESET 8'h00
`define FLAGS_RESET 4'h0
`define DEC_ONE 8'h01
`define NIBBLE_W 4
`endif

// ### hw/sub_skip_pkg.sv
// Types shared by the execution block: opcode selector and sequencer states.
// Assumes the params header sits on the include path.
`include "sub_skip_params.svh"
package sub_skip_pkg;
   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_SUB_WREG = 3'h1,
      OP_SUB_MEM = 3'h2,
      OP_DEC_MEM = 3'h3,
      OP_DEC_WREG = 3'h4
   } op_e;
   typedef enum logic [1:0] {
      ST_RUN = 2'h1,
      ST_DUMMY = 2'h2
   } seq_state_e;
endpackage

// ### tb/sub_skip_exec_monitor.sv
// Checker for the borrow-subtract and decrement-skip unit.
// Assumes a bind onto that unit; it sees only the unit's ports.
`timescale 1ns/10ps
module sub_skip_exec_monitor #(
   parameter int WIDTH = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_valid,
   input wire logic [2:0] i_op,
   input wire logic [WIDTH-1:0] i_mem_data,
   input wire logic [WIDTH-1:0] o_wreg,
   input wire logic [WIDTH-1:0] o_mem_wdata,
   input wire logic o_flag_ov,
   input wire logic o_flag_z,
   input wire logic o_flag_ac,
   input wire logic o_flag_c,
   input wire logic o_mem_we,
   input wire logic o_discard,
   input wire logic o_stall,
   input wire logic o_done
);
   logic [WIDTH-1:0] diff;
   logic [WIDTH-1:0] dec1;
   wire take = i_valid && !o_stall;
   wire dec = i_op == 3'h3 || i_op == 3'h4;
   wire one = i_mem_data == 8'h01;
   always_ff @(posedge i_ref_clk) diff <= o_wreg - i_mem_data - !o_flag_c;
   always_ff @(posedge i_ref_clk) dec1 <= i_mem_data - 8'h01;
   default clocking @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_resetn);
   sequence skip_s;
      o_discard && o_stall ##1 o_done && !o_stall;
   endsequence
   a_sub_to_wreg: assert property (
      take && i_op == 3'h1 |=> o_wreg == diff) else $error("sub wreg");
   a_sub_to_mem: assert property (
      take && i_op == 3'h2 |=> o_mem_we && o_mem_wdata == diff)
      else $error("sub mem");
   a_dec_mem_write: assert property (
      take && i_op == 3'h3 |=> o_mem_we && o_mem_wdata == dec1)
      else $error("dec mem");
   a_skip_mem_zero: assert property (
      take && i_op == 3'h3 && one |=> skip_s) else $error("skip mem");
   a_no_skip: assert property (
      take && dec && !one |=> o_done && !o_stall && !o_discard)
      else $error("no skip");
   a_dec_wreg_only: assert property (
      take && i_op == 3'h4 |=> !o_mem_we && o_wreg == dec1)
      else $error("dec wreg");
   a_skip_wreg_zero: assert property (
      take && i_op == 3'h4 && one |=> skip_s) else $error("skip wreg");
   a_dec_keeps_flags: assert property (
      take && dec |=> $stable({o_flag_ov, o_flag_z, o_flag_ac, o_flag_c}))
      else $error("flags");
endmodule

// ### tb/test_subtract_borrow_and_decrement_skip_exec.sv
// Testbench for the borrow-subtract and decrement-skip unit.
// Assumes the unit and its monitor are compiled first.
`timescale 1ns/10ps
module test_subtract_borrow_and_decrement_skip_exec;
   logic i_ref_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_valid = 1'b0;
   logic [2:0] i_op = 3'h0;
   logic [7:0] i_mem_data = 8'h00, o_wreg, o_mem_wdata, w = 8'h00;
   logic o_flag_ov, o_flag_z, o_flag_ac, o_flag_c, c = 1'b0;
   logic o_mem_we, o_discard, o_stall, o_done;
   int n_mismatch = 0;
   int check_count = 0;
   sub_skip_exec i_dut (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_valid(i_valid),
      .i_op(i_op),
      .i_mem_data(i_mem_data),
      .o_wreg(o_wreg),
      .o_flag_ov(o_flag_ov),
      .o_flag_z(o_flag_z),
      .o_flag_ac(o_flag_ac),
      .o_flag_c(o_flag_c),
      .o_mem_we(o_mem_we),
      .o_mem_wdata(o_mem_wdata),
      .o_discard(o_discard),
      .o_stall(o_stall),
      .o_done(o_done)
   );
   always #25 i_ref_clk = ~i_ref_clk;
   task chk(string s, logic [8:0] seen, logic [8:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task run(logic [2:0] op, logic [7:0] m);
      logic [8:0] d;
      logic [3:0] f;
      logic z;
      logic ov;
      logic ac;
      logic [4:0] lo;
      logic [3:0] e;
      f = {o_flag_ov, o_flag_z, o_flag_ac, o_flag_c};
      d = {1'b0, w} - {1'b0, m} - {8'h00, !c};
      lo = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, !c};
      ov = (w[7] != m[7]) && (d[7] != w[7]);
      ac = !lo[4];
      if (op > 3'h2) d = {1'b0, m - 8'h01};
      z = op > 3'h2 && d[7:0] == 8'h00;
      @(posedge i_ref_clk);
      i_valid <= 1'b1;
      i_op <= op;
      i_mem_data <= m;
      @(posedge i_ref_clk);
      i_valid <= z;
      i_op <= 3'h1;
      #1;
      if (op == 3'h1 || op == 3'h4) w = d[7:0];
      if (op < 3'h3) c = !d[8];
      e = {ov, d[7:0] == 8'h00, ac, c};
      chk("wreg", o_wreg, w);
      chk("we", o_mem_we, op == 3'h2 || op == 3'h3);
      if (op == 3'h2 || op == 3'h3) chk("wd", o_mem_wdata, d[7:0]);
      if (op > 3'h2)
         chk("fl", {o_flag_ov, o_flag_z, o_flag_ac, o_flag_c}, f);
      else
         chk("sf", {o_flag_ov, o_flag_z, o_flag_ac, o_flag_c}, e);
      chk("skip", {o_discard, o_stall, o_done}, {z, z, !z});
      @(posedge i_ref_clk);
      i_valid <= 1'b0;
      #1;
      chk("dummy", {o_done, o_wreg}, {z, w});
   endtask
   task t_dec_wreg();
      run(3'h4, 8'h50);
      run(3'h4, 8'h01);
      $display("end dec wreg");
   endtask
   task t_sub_wreg();
      run(3'h1, 8'h0F);
      run(3'h1, 8'h0F);
      run(3'h1, 8'hE0);
      $display("end sub wreg");
   endtask
   task t_sub_mem();
      run(3'h2, 8'h01);
      run(3'h2, 8'h00);
      $display("end sub mem");
   endtask
   task t_dec_mem();
      run(3'h3, 8'h00);
      run(3'h3, 8'h01);
      $display("end dec mem");
   endtask
   task t_overflow();
      run(3'h4, 8'h81);
      run(3'h1, 8'h01);
      $display("end overflow");
   endtask
   task print_verdict();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      t_dec_wreg();
      t_sub_wreg();
      t_sub_mem();
      t_dec_mem();
      t_overflow();
      print_verdict();
   end
endmodule
bind sub_skip_exec sub_skip_exec_monitor #(.WIDTH(WIDTH)) i_mon (
   .i_ref_clk(i_ref_clk),
   .i_resetn(i_resetn),
   .i_valid(i_valid),
   .i_op(i_op),
   .i_mem_data(i_mem_data),
   .o_wreg(o_wreg),
   .o_mem_wdata(o_mem_wdata),
   .o_flag_ov(o_flag_ov),
   .o_flag_z(o_flag_z),
   .o_flag_ac(o_flag_ac),
   .o_flag_c(o_flag_c),
   .o_mem_we(o_mem_we),
   .o_discard(o_discard),
   .o_stall(o_stall),
   .o_done(o_done)
);
